// [hdl/flash_ident_regs.svh]
// constants of the identification-read responder: opcodes, phase lengths, ident bytes
// assumes the includer compiles it once; the guard stops double definition
`ifndef FLASH_IDENT_REGS_SVH
`define FLASH_IDENT_REGS_SVH

// instruction codes
`define OP_LEGACY_SIG 8'hab
`define OP_STD_IDENT 8'h9f
`define OP_STD_IDENT_QUAD 8'haf
`define OP_PAIR_READ 8'h90
`define OP_UNIQUE_READ 8'h4b
`define OP_TABLE_READ 8'h5a

// phase lengths in bits or serial clocks
`define OPCODE_BITS 6'h08
`define ADDR_BITS 6'h18
`define SPI_STEP 6'h01
`define QUAD_STEP 6'h04
`define TABLE_DUMMY_CLOCKS 5'h08
`define DEFAULT_DUMMY_CLOCKS 5'h08
`define SPI_BITS_AFTER_LOAD 4'h7
`define QUAD_BITS_AFTER_LOAD 4'h4
`define STD_LAST_INDEX 4'h2
`define UNIQUE_LAST_INDEX 4'hf

// ident values: arbitrary neutral values, not those of any real part
`define MAKER_IDENT_BYTE 8'h5c
`define DEVICE_IDENT_BYTE 8'h3a
`define TYPE_CODE_BYTE 8'h41
`define CAPACITY_CODE_BYTE 8'h27
`define UNIQUE_NUMBER 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0
`define TABLE_FILL_BYTE 8'hff

// output enables per mode
`define SPI_OE 4'h2
`define QUAD_OE 4'hf

`endif

// [hdl/flash_ident_pkg.sv]
// types shared by the identification-read responder and its pin synchroniser
// assumes nothing beyond a SystemVerilog compiler
package flash_ident_pkg;

  // pins as they arrive from the host
  typedef struct packed {
    logic cs_b;
    logic sck;
    logic [3:0] io;
  } pin_in_t;

  // data pins driven back to the host
  typedef struct packed {
    logic [3:0] io_out;
    logic [3:0] io_oe;
  } pin_out_t;

  // frame controller states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_OPCODE = 6'h02,
    ST_ADDR = 6'h04,
    ST_DUMMY = 6'h08,
    ST_OUT = 6'h10,
    ST_IGNORE = 6'h20
  } state_t;

  // decoded instruction of the current frame
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_LEGACY = 3'h1,
    CMD_STD = 3'h2,
    CMD_PAIR = 3'h3,
    CMD_UNIQUE = 3'h4,
    CMD_TABLE = 3'h5
  } cmd_t;

endpackage

// [hdl/pin_sync.sv]
// two-flop synchroniser for chip select, serial clock and the four data pins
// assumes the pins are asynchronous to clock; only the second stage is read outside
`timescale 1ns/100ps
module pin_sync (
  input wire logic clock,
  input wire logic rst_b,
  input flash_ident_pkg::pin_in_t raw,
  output flash_ident_pkg::pin_in_t synced
);
  flash_ident_pkg::pin_in_t stage1;
  flash_ident_pkg::pin_in_t next_stage1;
  flash_ident_pkg::pin_in_t next_synced;

  // reset parks chip select high so the frame logic starts deselected
  always_comb begin
    if (!rst_b) begin
      next_stage1 = '{cs_b: 1'b1, sck: 1'b0, io: 4'h0};
      next_synced = '{cs_b: 1'b1, sck: 1'b0, io: 4'h0};
    end else begin
      next_stage1 = raw;
      next_synced = stage1;
    end
  end

  always_ff @(posedge clock) begin
    stage1 <= next_stage1;
    synced <= next_synced;
  end
endmodule

// [hdl/flash_ident_reads.sv]
// identification-read responder of a serial flash: signature, ident, pair,
// unique number and parameter table reads in single-line and quad modes
// assumes sck is far slower than clock (at least four clocks per half period)
// and that qpi_mode, write_in_progress_flag, read_dummy_field come from logic on clock
`timescale 1ns/100ps
`include "flash_ident_regs.svh"
module flash_ident_reads (
  input wire logic clock,
  input wire logic rst_b,
  input flash_ident_pkg::pin_in_t pins_in,
  input wire logic qpi_mode,
  input wire logic write_in_progress_flag,
  input wire logic [3:0] read_dummy_field,
  output flash_ident_pkg::pin_out_t pins_out
);
  flash_ident_pkg::pin_in_t pin;
  flash_ident_pkg::state_t state, next_state;
  flash_ident_pkg::cmd_t cmd, next_cmd;
  logic sck_prev, next_sck_prev;
  logic frame_quad, next_frame_quad;
  logic [7:0] op, next_op;
  logic [7:0] addr, next_addr;
  logic [5:0] cnt, next_cnt;
  logic [4:0] dummy_left, next_dummy_left;
  logic [7:0] sr, next_sr;
  logic [3:0] bits_left, next_bits_left;
  logic [3:0] byte_idx, next_byte_idx;
  logic [3:0] io_out, next_io_out;
  logic [3:0] io_oe, next_io_oe;
  logic sck_rise, sck_fall;
  logic [5:0] step;
  logic [7:0] op_shift, addr_shift, cur_byte;
  logic load_byte;

  pin_sync u_pin_sync (
    .clock(clock),
    .rst_b(rst_b),
    .raw(pins_in),
    .synced(pin)
  );

  // byte served at a given position of the output loop
  function automatic logic [7:0] ident_byte(input flash_ident_pkg::cmd_t c,
                                            input logic [3:0] idx, input logic a0);
    logic [127:0] uid;
    uid = `UNIQUE_NUMBER;
    unique case (c)
      flash_ident_pkg::CMD_LEGACY: ident_byte = `DEVICE_IDENT_BYTE;
      flash_ident_pkg::CMD_STD: begin
        if (idx == 4'h0) begin
          ident_byte = `MAKER_IDENT_BYTE;
        end else if (idx == 4'h1) begin
          ident_byte = `TYPE_CODE_BYTE;
        end else begin
          ident_byte = `CAPACITY_CODE_BYTE;
        end
      end
      // address bit zero flips which byte leads
      flash_ident_pkg::CMD_PAIR: begin
        ident_byte = (idx[0] ^ a0) ? `DEVICE_IDENT_BYTE : `MAKER_IDENT_BYTE;
      end
      flash_ident_pkg::CMD_UNIQUE: ident_byte = uid[8'(127 - 8 * idx) -: 8];
      // table contents are not modelled; every address reads the fill byte
      flash_ident_pkg::CMD_TABLE: ident_byte = `TABLE_FILL_BYTE;
      default: ident_byte = `TABLE_FILL_BYTE;
    endcase
  endfunction

  // position of the byte that follows idx in the loop of command c
  function automatic logic [3:0] next_index(input flash_ident_pkg::cmd_t c,
                                            input logic [3:0] idx);
    if (c == flash_ident_pkg::CMD_STD && idx == `STD_LAST_INDEX) begin
      next_index = 4'h0;
    end else begin
      next_index = idx + 4'h1; // wraps at 16 pair uses bit 0 only
    end
  endfunction

  // dummy clocks of the unique read; a zero field means the default of eight
  function automatic logic [4:0] dummy_count(input logic [3:0] field);
    dummy_count = (field == 4'h0) ? `DEFAULT_DUMMY_CLOCKS : {1'b0, field};
  endfunction

  // edge finding on the synchronised serial clock
  assign sck_rise = pin.sck & ~sck_prev;
  assign sck_fall = ~pin.sck & sck_prev;
  assign step = frame_quad ? `QUAD_STEP : `SPI_STEP;
  assign op_shift = frame_quad ? {op[3:0], pin.io} : {op[6:0], pin.io[0]};
  assign addr_shift = frame_quad ? {addr[3:0], pin.io} : {addr[6:0], pin.io[0]};
  assign load_byte = (state == flash_ident_pkg::ST_OUT) && sck_fall && (bits_left == 4'h0);
  assign cur_byte = load_byte ? ident_byte(cmd, byte_idx, addr[0]) : sr;
  assign pins_out = '{io_out: io_out, io_oe: io_oe};

  // frame controller: opcode, address or dummy bytes, dummy clocks, output loop
  always_comb begin
    next_state = state;
    next_cmd = cmd;
    next_sck_prev = pin.sck;
    next_frame_quad = frame_quad;
    next_op = op;
    next_addr = addr;
    next_cnt = cnt;
    next_dummy_left = dummy_left;
    next_sr = sr;
    next_bits_left = bits_left;
    next_byte_idx = byte_idx;
    next_io_out = io_out;
    next_io_oe = io_oe;
    if (!rst_b) begin
      next_state = flash_ident_pkg::ST_IDLE;
      next_cmd = flash_ident_pkg::CMD_NONE;
      next_sck_prev = 1'b0;
      next_frame_quad = 1'b0;
      next_op = 8'h00;
      next_addr = 8'h00;
      next_cnt = 6'h00;
      next_dummy_left = 5'h00;
      next_sr = 8'h00;
      next_bits_left = 4'h0;
      next_byte_idx = 4'h0;
      next_io_out = 4'h0;
      next_io_oe = 4'h0;
    end else if (pin.cs_b) begin
      // deselect ends any read at once and releases the pins
      next_state = flash_ident_pkg::ST_IDLE;
      next_cmd = flash_ident_pkg::CMD_NONE;
      next_io_oe = 4'h0;
      next_cnt = 6'h00;
    end else begin
      unique case (state)
        flash_ident_pkg::ST_IDLE: begin
          // mode is frozen per frame so a mid-frame change cannot split a byte
          next_state = flash_ident_pkg::ST_OPCODE;
          next_frame_quad = qpi_mode;
          next_op = 8'h00;
          next_cnt = 6'h00;
        end
        flash_ident_pkg::ST_OPCODE: begin
          if (sck_rise) begin
            next_op = op_shift;
            next_cnt = cnt + step;
            if (cnt + step == `OPCODE_BITS) begin
              next_cnt = 6'h00;
              next_byte_idx = 4'h0;
              next_bits_left = 4'h0;
              next_state = flash_ident_pkg::ST_ADDR;
              if (op_shift == `OP_LEGACY_SIG && write_in_progress_flag) begin
                next_state = flash_ident_pkg::ST_IGNORE;
              end else if (op_shift == `OP_LEGACY_SIG) begin
                next_cmd = flash_ident_pkg::CMD_LEGACY;
              end else if (op_shift == `OP_STD_IDENT ||
                           (op_shift == `OP_STD_IDENT_QUAD && frame_quad)) begin
                next_cmd = flash_ident_pkg::CMD_STD;
                next_state = flash_ident_pkg::ST_OUT;
              end else if (op_shift == `OP_PAIR_READ) begin
                next_cmd = flash_ident_pkg::CMD_PAIR;
              end else if (op_shift == `OP_UNIQUE_READ) begin
                next_cmd = flash_ident_pkg::CMD_UNIQUE;
              end else if (op_shift == `OP_TABLE_READ) begin
                next_cmd = flash_ident_pkg::CMD_TABLE;
              end else begin
                // other instructions belong to other blocks; stay silent
                next_state = flash_ident_pkg::ST_IGNORE;
              end
            end
          end
        end
        flash_ident_pkg::ST_ADDR: begin
          // three bytes: dummy bytes, dummy+address byte, or a full address
          if (sck_rise) begin
            next_addr = addr_shift;
            next_cnt = cnt + step;
            if (cnt + step == `ADDR_BITS) begin
              next_byte_idx = (cmd == flash_ident_pkg::CMD_UNIQUE) ?
                              addr_shift[3:0] : 4'h0;
              if (cmd == flash_ident_pkg::CMD_UNIQUE) begin
                next_state = flash_ident_pkg::ST_DUMMY;
                next_dummy_left = dummy_count(read_dummy_field);
              end else if (cmd == flash_ident_pkg::CMD_TABLE) begin
                next_state = flash_ident_pkg::ST_DUMMY;
                next_dummy_left = `TABLE_DUMMY_CLOCKS;
              end else begin
                next_state = flash_ident_pkg::ST_OUT;
              end
            end
          end
        end
        flash_ident_pkg::ST_DUMMY: begin
          // dummy clocks are counted in sck periods in either mode
          if (sck_rise) begin
            next_dummy_left = dummy_left - 5'h01;
            if (dummy_left == 5'h01) begin
              next_state = flash_ident_pkg::ST_OUT;
            end
          end
        end
        flash_ident_pkg::ST_OUT: begin
          // data changes only on falling sck so the host samples on the rise
          if (sck_fall) begin
            if (load_byte) begin
              next_byte_idx = next_index(cmd, byte_idx);
            end
            if (frame_quad) begin
              next_io_out = cur_byte[7:4];
              next_sr = {cur_byte[3:0], 4'h0};
              next_bits_left = load_byte ? `QUAD_BITS_AFTER_LOAD : bits_left - 4'h4;
              next_io_oe = `QUAD_OE;
            end else begin
              next_io_out = {2'b00, cur_byte[7], 1'b0};
              next_sr = {cur_byte[6:0], 1'b0};
              next_bits_left = load_byte ? `SPI_BITS_AFTER_LOAD : bits_left - 4'h1;
              next_io_oe = `SPI_OE;
            end
          end
        end
        flash_ident_pkg::ST_IGNORE: begin
          next_io_oe = 4'h0;
        end
        default: begin
          next_state = flash_ident_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    state <= next_state;
    cmd <= next_cmd;
    sck_prev <= next_sck_prev;
    frame_quad <= next_frame_quad;
    op <= next_op;
    addr <= next_addr;
    cnt <= next_cnt;
    dummy_left <= next_dummy_left;
    sr <= next_sr;
    bits_left <= next_bits_left;
    byte_idx <= next_byte_idx;
    io_out <= next_io_out;
    io_oe <= next_io_oe;
  end

  // deselect always returns to idle with pins released
  chk_deselect_to_idle: assert property (@(posedge clock) disable iff (!rst_b)
    pin.cs_b |=> (state == flash_ident_pkg::ST_IDLE) && (io_oe == 4'h0))
    else $error("chip select high did not end the read");

  // pins are only driven in the output phase
  chk_oe_only_out: assert property (@(posedge clock) disable iff (!rst_b)
    (io_oe != 4'h0)
    |-> $past(state == flash_ident_pkg::ST_OUT) || state == flash_ident_pkg::ST_OUT)
    else $error("pins driven outside the output phase");

  // signature opcode during a write is dropped
  chk_wip_ignore: assert property (@(posedge clock) disable iff (!rst_b)
    (state == flash_ident_pkg::ST_OPCODE && sck_rise && !pin.cs_b && cnt + step == `OPCODE_BITS
     && op_shift == `OP_LEGACY_SIG && write_in_progress_flag)
    |=> state == flash_ident_pkg::ST_IGNORE ##1 io_oe == 4'h0)
    else $error("signature opcode not ignored while writing");

  // single-line output presents the msb of a freshly loaded byte
  chk_spi_msb_first: assert property (@(posedge clock) disable iff (!rst_b)
    (load_byte && !frame_quad && !pin.cs_b)
    |=> io_out[1] == $past(cur_byte[7]) && io_oe == `SPI_OE && bits_left == `SPI_BITS_AFTER_LOAD)
    else $error("first serial bit is not the byte msb");

  // standard ident loops back to the maker byte after three bytes
  chk_std_wrap: assert property (@(posedge clock) disable iff (!rst_b)
    (load_byte && cmd == flash_ident_pkg::CMD_STD && byte_idx == `STD_LAST_INDEX && !pin.cs_b)
    |=> byte_idx == 4'h0)
    else $error("standard ident did not loop after three bytes");

  // standard ident starts with the maker byte
  chk_std_first_maker: assert property (@(posedge clock) disable iff (!rst_b)
    (load_byte && cmd == flash_ident_pkg::CMD_STD && byte_idx == 4'h0)
    |-> cur_byte == `MAKER_IDENT_BYTE)
    else $error("standard ident first byte is not the maker byte");

  // pair read order follows address bit zero
  chk_pair_order: assert property (@(posedge clock) disable iff (!rst_b)
    (load_byte && cmd == flash_ident_pkg::CMD_PAIR)
    |-> cur_byte == ((byte_idx[0] == addr[0]) ? `MAKER_IDENT_BYTE : `DEVICE_IDENT_BYTE))
    else $error("pair read byte order wrong");

  // unique number wraps after byte fifteen
  chk_unique_wrap: assert property (@(posedge clock) disable iff (!rst_b)
    (load_byte && cmd == flash_ident_pkg::CMD_UNIQUE && byte_idx == `UNIQUE_LAST_INDEX
     && !pin.cs_b) |=> byte_idx == 4'h0)
    else $error("unique number did not wrap");

  // table read always waits eight dummy clocks
  chk_table_dummy: assert property (@(posedge clock) disable iff (!rst_b)
    (state == flash_ident_pkg::ST_DUMMY && $past(state) == flash_ident_pkg::ST_ADDR
     && cmd == flash_ident_pkg::CMD_TABLE) |-> dummy_left == `TABLE_DUMMY_CLOCKS)
    else $error("table read dummy count is not eight");

  // legacy read keeps serving the device ident byte
  chk_legacy_repeat: assert property (@(posedge clock) disable iff (!rst_b)
    (load_byte && cmd == flash_ident_pkg::CMD_LEGACY) |-> cur_byte == `DEVICE_IDENT_BYTE)
    else $error("legacy read served a wrong byte");
endmodule

// [verification/flash_host_model.sv]
// host-side model of a serial flash controller: drives chip select, sck and io
// assumes mode 0 framing and a system clock far faster than sck
`timescale 1ns/100ps
module flash_host_model (
  input wire logic clock,
  output flash_ident_pkg::pin_in_t pins,
  input wire flash_ident_pkg::pin_out_t dut_out
);
  localparam int HALF = 5; // clocks per sck half period, giving a 50 ns period
  logic [3:0] q;
  logic [3:0] oe;

  initial begin
    pins = '{cs_b: 1'b1, sck: 1'b0, io: 4'h0};
  end

  // wait n clocks; a released bus toggles so a stale value never passes for data
  task automatic idle(input int n, input bit drv);
    repeat (n) begin
      @(posedge clock);
      if (!drv) begin
        pins.io <= ~pins.io;
      end
    end
  endtask

  // one sck period: fall with new data, rise half way, sample at its very end
  task automatic cycle(input bit drv, input logic [3:0] v);
    @(posedge clock);
    pins.sck <= 1'b0;
    pins.io <= drv ? v : ~pins.io;
    idle(HALF - 1, drv);
    @(posedge clock);
    pins.sck <= 1'b1;
    idle(HALF - 1, drv);
    #1;
    // a released pin reads back inverted, so a stale level never passes for data
    q = ~(dut_out.io_out ^ dut_out.io_oe);
    oe = dut_out.io_oe;
  endtask

  // opcode, address and dummy bytes, msb first, taken on rising sck
  task automatic send(input logic [7:0] b, input bit quad);
    if (quad) begin
      cycle(1'b1, b[7:4]);
      cycle(1'b1, b[3:0]);
    end else begin
      for (int i = 7; i >= 0; i--) begin
        cycle(1'b1, {3'h0, b[i]});
      end
    end
  endtask

  // one byte back from the device; o is the enable seen at its last bit
  task automatic recv(input bit quad, output logic [7:0] b, output logic [3:0] o);
    if (quad) begin
      cycle(1'b0, 4'h0);
      b[7:4] = q;
      cycle(1'b0, 4'h0);
      b[3:0] = q;
    end else begin
      for (int i = 7; i >= 0; i--) begin
        cycle(1'b0, 4'h0);
        b[i] = q[1];
      end
    end
    o = oe;
  endtask

  task automatic dummy(input int n, output logic [3:0] o);
    repeat (n) cycle(1'b0, 4'h0);
    o = oe;
  endtask

  task automatic open_frame();
    @(posedge clock);
    pins.cs_b <= 1'b0;
    pins.sck <= 1'b0;
    idle(4, 1'b1);
  endtask

  // sck returns low before cs_b rises; the gap is well over three clocks
  task automatic close_frame();
    @(posedge clock);
    pins.sck <= 1'b0;
    idle(HALF, 1'b1);
    pins.cs_b <= 1'b1;
    idle(8, 1'b1);
    #1;
  endtask
endmodule

// [verification/flash_identification_reads_bench.sv]
// self-checking bench for the identification-read responder
// assumes flash_host_model drives the pins and the header holds the ident values
`timescale 1ns/100ps
`include "flash_ident_regs.svh"
module flash_identification_reads_bench;
  logic clock;
  logic rst_b;
  logic qpi_mode;
  logic write_in_progress_flag;
  logic [3:0] read_dummy_field;
  flash_ident_pkg::pin_in_t pins_in;
  flash_ident_pkg::pin_out_t pins_out;
  int n_errors;
  int num_checks;
  int cycles = 0;

  flash_ident_reads u_dut (.clock(clock), .rst_b(rst_b), .pins_in(pins_in),
    .qpi_mode(qpi_mode), .write_in_progress_flag(write_in_progress_flag),
    .read_dummy_field(read_dummy_field), .pins_out(pins_out));

  flash_host_model u_host (.clock(clock), .pins(pins_in), .dut_out(pins_out));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // the ceiling leaves a wide margin over the frames below
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_errors = n_errors + 1;
      test_done();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // mode changes only between frames, since the design freezes it at cs_b fall
  task automatic set_mode(input bit quad, input logic [3:0] field);
    @(posedge clock);
    qpi_mode <= quad;
    read_dummy_field <= field;
  endtask

  function automatic logic [7:0] oe_of(input bit quad);
    return {4'h0, quad ? `QUAD_OE : `SPI_OE};
  endfunction

  task automatic end_frame();
    u_host.close_frame();
    chk({4'h0, pins_out.io_oe}, 8'h00);
  endtask

  // signature read: three dummy bytes, then the device byte over and over
  task automatic t_legacy(input bit quad);
    logic [7:0] b;
    logic [3:0] o;
    set_mode(quad, 4'h0);
    u_host.open_frame();
    u_host.send(`OP_LEGACY_SIG, quad);
    repeat (3) u_host.send(8'ha5, quad);
    for (int i = 0; i < 3; i++) begin
      u_host.recv(quad, b, o);
      chk(b, `DEVICE_IDENT_BYTE);
    end
    chk({4'h0, o}, oe_of(quad));
    end_frame();
  endtask

  // signature opcode during a write cycle must leave the pins undriven
  task automatic t_busy();
    logic [7:0] b;
    logic [3:0] o;
    set_mode(1'b0, 4'h0);
    write_in_progress_flag <= 1'b1;
    u_host.open_frame();
    u_host.send(`OP_LEGACY_SIG, 1'b0);
    repeat (3) u_host.send(8'h00, 1'b0);
    u_host.recv(1'b0, b, o);
    chk({4'h0, o}, 8'h00);
    end_frame();
    @(posedge clock);
    write_in_progress_flag <= 1'b0;
  endtask

  // maker, type, capacity looping; a refused opcode keeps the enable low
  task automatic t_std(input logic [7:0] op, input bit quad, input bit ok);
    logic [7:0] b;
    logic [3:0] o;
    logic [7:0] exp [3] = '{`MAKER_IDENT_BYTE, `TYPE_CODE_BYTE, `CAPACITY_CODE_BYTE};
    set_mode(quad, 4'h0);
    u_host.open_frame();
    u_host.send(op, quad);
    for (int i = 0; i < 6; i++) begin
      u_host.recv(quad, b, o);
      chk(ok ? b : {4'h0, o}, ok ? exp[i % 3] : 8'h00);
    end
    end_frame();
  endtask

  // reset in mid-read releases the pins at once; later frames show a clean restart
  task automatic t_reset();
    logic [7:0] b;
    logic [3:0] o;
    set_mode(1'b0, 4'h0);
    u_host.open_frame();
    u_host.send(`OP_STD_IDENT, 1'b0);
    u_host.recv(1'b0, b, o);
    chk(b, `MAKER_IDENT_BYTE);
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (5) @(posedge clock);
    #1;
    chk({4'h0, pins_out.io_oe}, 8'h00);
    @(posedge clock);
    rst_b <= 1'b1;
    end_frame();
  endtask

  // maker and device bytes alternate, first one picked by address bit zero
  task automatic t_pair(input bit quad, input bit a0);
    logic [7:0] b;
    logic [3:0] o;
    set_mode(quad, 4'h0);
    u_host.open_frame();
    u_host.send(`OP_PAIR_READ, quad);
    u_host.send(8'h00, quad);
    u_host.send(8'h00, quad);
    u_host.send({7'h2a, a0}, quad);
    for (int i = 0; i < 4; i++) begin
      u_host.recv(quad, b, o);
      chk(b, (i[0] ^ a0) ? `DEVICE_IDENT_BYTE : `MAKER_IDENT_BYTE);
    end
    end_frame();
  endtask

  // unique number: dummy count from the field, start byte from the low nibble, wraps
  task automatic t_unique(input bit quad, input logic [3:0] field, input logic [3:0] lo);
    logic [7:0] b;
    logic [3:0] o;
    logic [127:0] u;
    int n;
    u = `UNIQUE_NUMBER;
    n = (field == 4'h0) ? 8 : int'(field);
    set_mode(quad, field);
    u_host.open_frame();
    u_host.send(`OP_UNIQUE_READ, quad);
    u_host.send(8'hc3, quad);
    u_host.send(8'h5e, quad); // upper bits arbitrary, bit 8 zero
    u_host.send({4'h0, lo}, quad);
    u_host.dummy(n, o);
    chk({4'h0, o}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      u_host.recv(quad, b, o);
      chk(b, u[127 - 8 * ((lo + i) % 16) -: 8]);
    end
    end_frame();
  endtask

  // table read: eight dummy clocks whatever the field says; data itself not checked
  task automatic t_table(input bit quad);
    logic [7:0] b;
    logic [3:0] o;
    set_mode(quad, 4'h3);
    u_host.open_frame();
    u_host.send(`OP_TABLE_READ, quad);
    repeat (3) u_host.send(8'h00, quad);
    u_host.dummy(8, o);
    chk({4'h0, o}, 8'h00);
    u_host.recv(quad, b, o);
    chk({4'h0, o}, oe_of(quad));
    end_frame();
  endtask

  initial begin
    n_errors = 0;
    num_checks = 0;
    rst_b = 1'b0;
    qpi_mode = 1'b0;
    write_in_progress_flag = 1'b0;
    read_dummy_field = 4'h0;
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    t_legacy(1'b0);
    t_legacy(1'b1);
    t_busy();
    t_legacy(1'b0);
    t_std(`OP_STD_IDENT, 1'b0, 1'b1);
    t_std(`OP_STD_IDENT, 1'b1, 1'b1);
    t_std(`OP_STD_IDENT_QUAD, 1'b1, 1'b1);
    t_std(`OP_STD_IDENT_QUAD, 1'b0, 1'b0);
    t_reset();
    t_pair(1'b0, 1'b0);
    t_pair(1'b0, 1'b1);
    t_pair(1'b1, 1'b1);
    t_unique(1'b0, 4'h0, 4'he);
    t_unique(1'b1, 4'h3, 4'hf);
    t_unique(1'b0, 4'ha, 4'h0);
    t_table(1'b0);
    t_table(1'b1);
    test_done();
  end
endmodule
